// ---- hdl/tosup_cfg.svh ----
// Constants for the timeout supervisor: offsets, fields, reset values and counts
`ifndef TOSUP_CFG_SVH
`define TOSUP_CFG_SVH

// ---------------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------------
`define TOSUP_CNT_W 32
`define TOSUP_LEN_W 8
`define TOSUP_ADDR_W 8
`define TOSUP_DATA_W 32
`define TOSUP_RANGE_W 4

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define TOSUP_OFS_CTRL 8'h00
`define TOSUP_OFS_RSTLEN 8'h04
`define TOSUP_OFS_RESTART 8'h08
`define TOSUP_OFS_COUNT 8'h0C
`define TOSUP_OFS_INT_STAT 8'h10
`define TOSUP_OFS_INT_MASK 8'h14
`define TOSUP_OFS_STATE 8'h18

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define TOSUP_CTRL_EN_BIT 0
`define TOSUP_CTRL_MODE_BIT 1
`define TOSUP_CTRL_RANGE_LO 4
`define TOSUP_CTRL_RANGE_HI 7
`define TOSUP_INT_FIRST_BIT 0
`define TOSUP_INT_RESET_BIT 1
`define TOSUP_INT_W 2
`define TOSUP_STATE_RST_BIT 0
`define TOSUP_STATE_EN_BIT 1

// ---------------------------------------------------------------------------
// Reset values, keys and the preset shift
// ---------------------------------------------------------------------------
`define TOSUP_CTRL_RST 8'h00
`define TOSUP_RSTLEN_RST 8'h10
`define TOSUP_MASK_RST 2'h0
`define TOSUP_CNT_RST 32'h0000_FFFF
`define TOSUP_RESTART_KEY 8'h76
`define TOSUP_PRESET_SHIFT 6'h10

`endif

// ---- hdl/tosup_pkg.sv ----
// Types shared by the timeout supervisor modules
`default_nettype none
package tosup_pkg;

    // Bus slave handshake states, one-hot
    typedef enum logic [1:0] {
        TOSUP_BUS_IDLE = 2'b01,
        TOSUP_BUS_ACK = 2'b10
    } tosup_bus_state_type;

    // Response on timeout
    typedef enum logic {
        TOSUP_MODE_DIRECT = 1'b0,
        TOSUP_MODE_TWO_STAGE = 1'b1
    } tosup_mode_type;

endpackage : tosup_pkg
`default_nettype wire

// ---- hdl/tosup_counter.sv ----
// Down-counter with a preset chosen from sixteen ranges
`timescale 1ns/1ps
`default_nettype none
`include "tosup_cfg.svh"
module tosup_counter
    import tosup_pkg::*;
#(
    parameter int CNT_W = `TOSUP_CNT_W,
    // Preset exponent base; a lower value shortens every range alike
    parameter int PRE_SHIFT = `TOSUP_PRESET_SHIFT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic reload,
    input wire logic [`TOSUP_RANGE_W-1:0] range,
    output logic [CNT_W-1:0] count,
    output logic expire
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic expire_reg;
    logic expire_next;

    // Range r gives a preset of 2^(PRE_SHIFT+r)-1 cycles
    function automatic logic [CNT_W-1:0] preset_of(input logic [`TOSUP_RANGE_W-1:0] r);
        logic [CNT_W-1:0] one;
        one = CNT_W'(1);
        preset_of = (one << (PRE_SHIFT + int'(r))) - one;
    endfunction : preset_of

    // Next count: hold preset while off, reload on restart, reload the preset and flag expiry at zero
    always_comb begin
        count_next = count_reg;
        expire_next = 1'b0;
        if (!enable) begin
            count_next = preset_of(range);
        end else if (reload) begin
            count_next = preset_of(range);
        end else if (count_reg == '0) begin
            expire_next = 1'b1;
            count_next = preset_of(range);
        end else begin
            count_next = count_reg - CNT_W'(1);
        end
    end

    // Counted on the bus clock itself, no separate oscillator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= CNT_W'(`TOSUP_CNT_RST);
            expire_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            expire_reg <= expire_next;
        end
    end

    assign count = count_reg;
    assign expire = expire_reg;

endmodule : tosup_counter
`default_nettype wire

// ---- hdl/tosup_rstgen.sv ----
// Reset pulse generator with programmable length
`timescale 1ns/1ps
`default_nettype none
`include "tosup_cfg.svh"
module tosup_rstgen
    import tosup_pkg::*;
#(
    parameter int LEN_W = `TOSUP_LEN_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [LEN_W-1:0] length,
    output logic active
);

    logic active_reg;
    logic active_next;
    logic [LEN_W-1:0] left_reg;
    logic [LEN_W-1:0] left_next;

    // A length of zero still gives one cycle so a reset is never swallowed
    always_comb begin
        active_next = active_reg;
        left_next = left_reg;
        if (!active_reg && start) begin
            active_next = 1'b1;
            left_next = (length == '0) ? LEN_W'(1) : length;
        end else if (active_reg) begin
            if (left_reg <= LEN_W'(1)) begin
                active_next = 1'b0;
            end else begin
                left_next = left_reg - LEN_W'(1);
            end
        end
    end

    // Pulse state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_reg <= 1'b0;
            left_reg <= '0;
        end else begin
            active_reg <= active_next;
            left_reg <= left_next;
        end
    end

    assign active = active_reg;

endmodule : tosup_rstgen
`default_nettype wire

// ---- hdl/tosup_top.sv ----
// Timeout supervisor top: Avalon-MM registers, timeout response and interrupt
//
// Notes on behaviour
// - Timeout counter is 32 bits wide and decrements once per counting clock.
// - Counting clock is the bus clock; no separate oscillator.
// - Counter loads a preset, counts down, and zero means timeout.
// - Software selects one of two timeout response modes.
// - Direct mode asserts system reset at expiry without an interrupt; the code sets the reset status bit, which raises IRQ when unmasked.
// - Two-stage mode interrupts first, restarts, resets at second uncleared expiry.
// - Reset output lasts a software-programmed number of clock cycles.
// - Sixteen selectable ranges each give a distinct preset load value.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "tosup_cfg.svh"
module tosup_top
    import tosup_pkg::*;
#(
    parameter int CNT_W = `TOSUP_CNT_W,
    parameter int LEN_W = `TOSUP_LEN_W,
    parameter int PRE_SHIFT = `TOSUP_PRESET_SHIFT
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic [`TOSUP_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [`TOSUP_DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [`TOSUP_DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic IRQ,
    output logic SYS_RST_REQ
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    tosup_bus_state_type bus_state_reg;
    tosup_bus_state_type bus_state_next;
    logic [`TOSUP_DATA_W-1:0] rdata_reg;
    logic [`TOSUP_DATA_W-1:0] rdata_next;
    logic wait_reg;
    logic wait_next;

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [LEN_W-1:0] rstlen_reg;
    logic [LEN_W-1:0] rstlen_next;
    logic [`TOSUP_INT_W-1:0] stat_reg;
    logic [`TOSUP_INT_W-1:0] stat_next;
    logic [`TOSUP_INT_W-1:0] mask_reg;
    logic [`TOSUP_INT_W-1:0] mask_next;
    logic irq_reg;
    logic irq_next;

    logic commit_wr;
    logic restart_hit;
    logic [`TOSUP_INT_W-1:0] stat_clr;
    logic [`TOSUP_INT_W-1:0] stat_set;
    logic fire_reset;
    logic enable;
    tosup_mode_type mode;
    logic [`TOSUP_RANGE_W-1:0] range;
    logic [CNT_W-1:0] count;
    logic expire;
    logic rst_active;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Byte-lane merge so partial writes leave other lanes untouched
    function automatic logic [`TOSUP_DATA_W-1:0] lane_merge(
        input logic [`TOSUP_DATA_W-1:0] old_val,
        input logic [`TOSUP_DATA_W-1:0] new_val,
        input logic [3:0] be
    );
        logic [`TOSUP_DATA_W-1:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        lane_merge = res;
    endfunction : lane_merge

    // Word-aligned decode of one register offset
    function automatic logic hit(
        input logic [`TOSUP_ADDR_W-1:0] addr,
        input logic [`TOSUP_ADDR_W-1:0] ofs
    );
        hit = (addr[`TOSUP_ADDR_W-1:2] == ofs[`TOSUP_ADDR_W-1:2]);
    endfunction : hit

    // ------------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------------

    // Mode bit steers what an expiry does
    assign enable = ctrl_reg[`TOSUP_CTRL_EN_BIT];
    assign mode = tosup_mode_type'(ctrl_reg[`TOSUP_CTRL_MODE_BIT]);
    assign range = ctrl_reg[`TOSUP_CTRL_RANGE_HI:`TOSUP_CTRL_RANGE_LO];

    // ------------------------------------------------------------------------
    // Bus slave handshake
    // ------------------------------------------------------------------------

    // Every access takes one wait cycle; the write lands on the edge where
    // waitrequest is seen low, which is the same edge the master samples it
    assign commit_wr = AVS_WRITE && !wait_reg;

    // Handshake and read data path
    always_comb begin
        bus_state_next = bus_state_reg;
        wait_next = wait_reg;
        rdata_next = rdata_reg;
        case (bus_state_reg)
            TOSUP_BUS_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    bus_state_next = TOSUP_BUS_ACK;
                    wait_next = 1'b0;
                    rdata_next = '0;
                    if (AVS_READ) begin
                        if (hit(AVS_ADDRESS, `TOSUP_OFS_CTRL)) begin
                            rdata_next[7:0] = ctrl_reg;
                        end else if (hit(AVS_ADDRESS, `TOSUP_OFS_RSTLEN)) begin
                            rdata_next[LEN_W-1:0] = rstlen_reg;
                        end else if (hit(AVS_ADDRESS, `TOSUP_OFS_COUNT)) begin
                            rdata_next[CNT_W-1:0] = count;
                        end else if (hit(AVS_ADDRESS, `TOSUP_OFS_INT_STAT)) begin
                            rdata_next[`TOSUP_INT_W-1:0] = stat_reg;
                        end else if (hit(AVS_ADDRESS, `TOSUP_OFS_INT_MASK)) begin
                            rdata_next[`TOSUP_INT_W-1:0] = mask_reg;
                        end else if (hit(AVS_ADDRESS, `TOSUP_OFS_STATE)) begin
                            rdata_next[`TOSUP_STATE_RST_BIT] = rst_active;
                            rdata_next[`TOSUP_STATE_EN_BIT] = enable;
                        end
                    end
                end
            end
            TOSUP_BUS_ACK: begin
                // Back to waiting so the next request gets its own cycle
                bus_state_next = TOSUP_BUS_IDLE;
                wait_next = 1'b1;
            end
            default: begin
                bus_state_next = TOSUP_BUS_IDLE;
                wait_next = 1'b1;
            end
        endcase
    end

    // Handshake registers
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            bus_state_reg <= TOSUP_BUS_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------------

    // A restart needs the key in the low lane so stray writes cannot feed it
    assign restart_hit = commit_wr && hit(AVS_ADDRESS, `TOSUP_OFS_RESTART)
        && AVS_BYTEENABLE[0] && (AVS_WRITEDATA[7:0] == `TOSUP_RESTART_KEY);

    // Write-one-to-clear on the status lane
    always_comb begin
        stat_clr = '0;
        if (commit_wr && hit(AVS_ADDRESS, `TOSUP_OFS_INT_STAT) && AVS_BYTEENABLE[0]) begin
            stat_clr = AVS_WRITEDATA[`TOSUP_INT_W-1:0];
        end
        if (restart_hit) begin
            stat_clr[`TOSUP_INT_FIRST_BIT] = 1'b1;
        end
    end

    // Control, pulse length and mask registers
    always_comb begin
        logic [`TOSUP_DATA_W-1:0] merged;
        merged = '0;
        ctrl_next = ctrl_reg;
        rstlen_next = rstlen_reg;
        mask_next = mask_reg;
        if (commit_wr) begin
            if (hit(AVS_ADDRESS, `TOSUP_OFS_CTRL)) begin
                merged = lane_merge({24'h000000, ctrl_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
                ctrl_next = merged[7:0];
            end else if (hit(AVS_ADDRESS, `TOSUP_OFS_RSTLEN)) begin
                merged = lane_merge({{(`TOSUP_DATA_W-LEN_W){1'b0}}, rstlen_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
                rstlen_next = merged[LEN_W-1:0];
            end else if (hit(AVS_ADDRESS, `TOSUP_OFS_INT_MASK)) begin
                merged = lane_merge({{(`TOSUP_DATA_W-`TOSUP_INT_W){1'b0}}, mask_reg}, AVS_WRITEDATA,
                    AVS_BYTEENABLE);
                mask_next = merged[`TOSUP_INT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Timeout response
    // ------------------------------------------------------------------------

    // Direct mode resets at once; two-stage only when the first flag is
    // still pending. The flag is read before this cycle's clear so a clear
    // racing the second expiry is too late to save the system.
    always_comb begin
        stat_set = '0;
        fire_reset = 1'b0;
        if (expire && enable) begin
            if (mode == TOSUP_MODE_DIRECT) begin
                fire_reset = 1'b1;
            end else if (stat_reg[`TOSUP_INT_FIRST_BIT]) begin
                fire_reset = 1'b1;
            end else begin
                stat_set[`TOSUP_INT_FIRST_BIT] = 1'b1;
            end
        end
        if (fire_reset) begin
            stat_set[`TOSUP_INT_RESET_BIT] = 1'b1;
        end
    end

    // Sticky status: a set in the same cycle as a clear wins
    always_comb begin
        stat_next = (stat_reg & ~stat_clr) | stat_set;
        irq_next = |(stat_next & mask_next);
    end

    // Configuration and status registers
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_reg <= `TOSUP_CTRL_RST;
            rstlen_reg <= LEN_W'(`TOSUP_RSTLEN_RST);
            stat_reg <= '0;
            mask_reg <= `TOSUP_MASK_RST;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            rstlen_reg <= rstlen_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------------------
    // Counter and reset pulse
    // ------------------------------------------------------------------------

    // Counting on CLK_SYS; a restart reloads the selected preset
    tosup_counter #(
        .CNT_W(CNT_W),
        .PRE_SHIFT(PRE_SHIFT)
    ) u_counter (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .enable(enable),
        .reload(restart_hit),
        .range(range),
        .count(count),
        .expire(expire)
    );

    // Pulse length is taken when the pulse starts; later writes do not stretch it
    tosup_rstgen #(
        .LEN_W(LEN_W)
    ) u_rstgen (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .start(fire_reset),
        .length(rstlen_reg),
        .active(rst_active)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // All driven from flip-flops
    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign IRQ = irq_reg;
    assign SYS_RST_REQ = rst_active;

endmodule : tosup_top
`default_nettype wire

// ---- verification/tosup_properties.sv ----
// Port-level checker for the timeout supervisor
`timescale 1ns/1ps
`default_nettype none
`include "tosup_cfg.svh"
module tosup_properties
    import tosup_pkg::*;
#(
    parameter int CNT_W = `TOSUP_CNT_W,
    parameter int LEN_W = `TOSUP_LEN_W,
    parameter int PRE_SHIFT = `TOSUP_PRESET_SHIFT
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic [`TOSUP_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [`TOSUP_DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [`TOSUP_DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic IRQ,
    input wire logic SYS_RST_REQ
);
    // ---------------------------------------------------------------
    // Shadow state rebuilt from bus writes and the reset output
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    logic land;
    logic prev_reg, prev_next;
    logic [16:0] gap_reg, gap_next;
    logic [LEN_W:0] hi_reg, hi_next;
    logic [LEN_W-1:0] len_reg, len_next, plen_reg, plen_next;
    logic [1:0] msk_reg, msk_next;
    assign land = AVS_WRITE && !AVS_WAITREQUEST;
    // Gap counts from each pulse start, so a long pulse cannot hide a short period
    always_comb begin
        prev_next = SYS_RST_REQ;
        gap_next = (SYS_RST_REQ && !prev_reg) ? 17'h0 : gap_reg + {16'h0, gap_reg != 17'h1FFFF};
        hi_next = SYS_RST_REQ ? hi_reg + 1'b1 : '0;
        len_next = len_reg;
        msk_next = msk_reg;
        plen_next = plen_reg;
        if (land && AVS_ADDRESS[7:2] == 6'(`TOSUP_OFS_RSTLEN >> 2) && AVS_BYTEENABLE[0]) begin
            len_next = AVS_WRITEDATA[LEN_W-1:0];
        end
        if (land && AVS_ADDRESS[7:2] == 6'(`TOSUP_OFS_INT_MASK >> 2) && AVS_BYTEENABLE[0]) begin
            msk_next = AVS_WRITEDATA[1:0];
        end
        if (SYS_RST_REQ && hi_reg == '0) begin
            plen_next = len_reg;
        end
    end
    // Registers of the shadow state
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            prev_reg <= 1'b0;
            gap_reg <= 17'h0;
            hi_reg <= '0;
            len_reg <= `TOSUP_RSTLEN_RST;
            plen_reg <= `TOSUP_RSTLEN_RST;
            msk_reg <= `TOSUP_MASK_RST;
        end else begin
            prev_reg <= prev_next;
            gap_reg <= gap_next;
            hi_reg <= hi_next;
            len_reg <= len_next;
            plen_reg <= plen_next;
            msk_reg <= msk_next;
        end
    end
    // ---------------------------------------------------------------
    // Assertions and covers
    // ---------------------------------------------------------------
    AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus request not answered after one wait cycle");
    AST_WAIT_PULSE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    AST_NO_STRAY: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
        else $error("answer without a request");
    AST_RDATA_HOLD: assert property ($changed(AVS_READDATA) |-> $past((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST))
        else $error("read data changed outside an access");
    AST_IRQ_CLEAR: assert property ($fell(IRQ) |-> land || $past(land) || $past(land, 2))
        else $error("interrupt dropped without a bus write");
    AST_IRQ_MASK: assert property ($rose(IRQ) |-> msk_reg != 2'h0)
        else $error("interrupt raised while fully masked");
    AST_RST_GAP: assert property ($rose(SYS_RST_REQ) |-> gap_reg >= 17'((1 << PRE_SHIFT) - 1))
        else $error("reset request sooner than the shortest timeout");
    AST_RST_LEN: assert property ($fell(SYS_RST_REQ) |-> hi_reg == ((plen_reg == '0) ? 1 : plen_reg))
        else $error("reset pulse length differs from programmed length");
    COV_RST: cover property ($rose(SYS_RST_REQ));
    COV_IRQ: cover property ($rose(IRQ));
    COV_IRQ_CLR: cover property ($fell(IRQ));
    COV_READ: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule : tosup_properties
bind tosup_top tosup_properties #(.CNT_W(CNT_W), .LEN_W(LEN_W), .PRE_SHIFT(PRE_SHIFT))
    u_props (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .IRQ(IRQ), .SYS_RST_REQ(SYS_RST_REQ));
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the timeout supervisor
`timescale 1ns/1ps
`default_nettype none
`include "tosup_cfg.svh"
module tb;
    // ---------------------------------------------------------------
    // Stimulus and scoreboard state
    // ---------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    wire logic [31:0] rdata;
    wire logic wait_r;
    wire logic irq;
    wire logic rst_req;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int hi = 0;
    int rd_cyc = 0;
    logic [31:0] rd_val = 32'h0;
    logic [31:0] exp_q[$];
    bit chk_q[$];
    int len_q[$];
    // Short presets keep each expiry to about a hundred cycles
    localparam int PRE_SHIFT = 7;
    tosup_top #(.PRE_SHIFT(PRE_SHIFT)) DUT (.CLK_SYS(clk_sys), .ARST_N(arst_n), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
        .IRQ(irq), .SYS_RST_REQ(rst_req));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    // Watcher: scores reads in issue order, times reset pulses, cuts a hang
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rd && wait_r === 1'b0) begin
            rd_val = rdata;
            rd_cyc = cyc;
            if (chk_q.pop_front()) begin
                check("readdata", rdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
        if (rst_req === 1'b1) begin
            hi++;
        end else if (hi != 0) begin
            check("pulse length", 32'(hi), 32'(len_q.pop_front()));
            hi = 0;
        end
        // Ceiling about four times the expected run; kept last so nothing follows the finish
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end
    // ---------------------------------------------------------------
    // Bus master tasks
    // ---------------------------------------------------------------
    // One extra edge after release so a following call never re-drives a strobe in the same step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= ~w;
        wr <= w;
        @(posedge clk_sys);
        while (wait_r !== 1'b0) begin
            @(posedge clk_sys);
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input bit c);
        exp_q.push_back(e);
        chk_q.push_back(c);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rdc
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wrt
    // Registered flags lag a landed write by up to one edge
    task automatic settle;
        repeat (2) @(posedge clk_sys);
    endtask : settle
    // Main sequence
    initial begin
        logic [31:0] a;
        int c0;
        int len;
        void'($urandom(13));
        len = 1 + $urandom_range(30);
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rdc(`TOSUP_OFS_CTRL, 32'h0, 1);
        rdc(`TOSUP_OFS_RSTLEN, 32'h10, 1);
        rdc(`TOSUP_OFS_INT_STAT, 32'h0, 1);
        rdc(`TOSUP_OFS_COUNT, (32'h1 << PRE_SHIFT) - 32'h1, 1);
        wrt(8'h1C, 32'hFFFFFFFF);
        rdc(8'h1C, 32'h0, 1);
        for (int r = 15; r >= 0; r--) begin
            wrt(`TOSUP_OFS_CTRL, 32'(r) << 4);
            rdc(`TOSUP_OFS_COUNT, (32'h1 << (PRE_SHIFT + r)) - 32'h1, 1);
        end
        bus(1'b1, `TOSUP_OFS_RSTLEN, 32'hFF, 4'h0);
        rdc(`TOSUP_OFS_RSTLEN, 32'h10, 1);
        wrt(`TOSUP_OFS_RSTLEN, 32'(len));
        rdc(`TOSUP_OFS_RSTLEN, 32'(len), 1);
        // Two-stage: count down each clock, first expiry only interrupts
        wrt(`TOSUP_OFS_CTRL, 32'h3);
        rdc(`TOSUP_OFS_COUNT, 32'h0, 0);
        a = rd_val;
        c0 = rd_cyc;
        rdc(`TOSUP_OFS_COUNT, 32'h0, 0);
        check("count step", rd_val, a - 32'(rd_cyc - c0));
        do rdc(`TOSUP_OFS_INT_STAT, 32'h0, 0); while (rd_val[0] !== 1'b1);
        check("masked irq", 32'(irq), 32'h0);
        rdc(`TOSUP_OFS_INT_STAT, 32'h1, 1);
        wrt(`TOSUP_OFS_INT_MASK, 32'h3);
        settle();
        check("irq", 32'(irq), 32'h1);
        wrt(`TOSUP_OFS_RESTART, 32'h0);
        rdc(`TOSUP_OFS_INT_STAT, 32'h1, 1);
        wrt(`TOSUP_OFS_RESTART, 32'h76);
        rdc(`TOSUP_OFS_INT_STAT, 32'h0, 1);
        settle();
        check("irq", 32'(irq), 32'h0);
        // Two-stage again: flag at one expiry, reset at the next while it stands
        len_q.push_back(len);
        do rdc(`TOSUP_OFS_INT_STAT, 32'h0, 0); while (rd_val[1] !== 1'b1);
        check("two-stage flags", rd_val, 32'h3);
        wrt(`TOSUP_OFS_INT_STAT, 32'h3);
        // Direct mode: reset without the first-stage flag
        wrt(`TOSUP_OFS_CTRL, 32'h1);
        len_q.push_back(len);
        do rdc(`TOSUP_OFS_INT_STAT, 32'h0, 0); while (rd_val[1] !== 1'b1);
        repeat (len + 4) @(posedge clk_sys);
        rdc(`TOSUP_OFS_INT_STAT, 32'h2, 1);
        check("irq", 32'(irq), 32'h1);
        wrt(`TOSUP_OFS_INT_STAT, 32'h2);
        rdc(`TOSUP_OFS_INT_STAT, 32'h0, 1);
        settle();
        check("irq", 32'(irq), 32'h0);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rdc(`TOSUP_OFS_RSTLEN, 32'h10, 1);
        test_done();
    end
endmodule : tb
`default_nettype wire
